// [hdl/pss_delay_timer.sv]
`timescale 1ns/1ns
module pss_delay_timer (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        load_in,
  input  wire logic [31:0] load_val_in,
  input  wire logic        abort_in,
  output logic             done_out
);
  typedef struct packed {
    logic        run;
    logic [31:0] cnt;
  } pss_tmr_t;

  pss_tmr_t s_ff;
  pss_tmr_t nxt_s;

  // done pulses on the last counted cycle; a value of one is the minimum
  assign done_out = s_ff.run & (s_ff.cnt == 32'h1) & ~abort_in & ~load_in;

  always_comb begin
    nxt_s = s_ff;
    if (abort_in) begin
      nxt_s.run = 1'b0;
    end else if (load_in) begin
      nxt_s.run = 1'b1;
      nxt_s.cnt = load_val_in;
    end else if (s_ff.run) begin
      nxt_s.run = s_ff.cnt > 32'h1;
      nxt_s.cnt = s_ff.cnt - 32'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule : pss_delay_timer

// [hdl/pss_pkg.sv]
package pss_pkg;
  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
  localparam int unsigned WAKE_US        = 100;
  localparam int unsigned STEP_UNIT_US   = 250;
  localparam int unsigned RST_UNIT_US    = 1000;
  localparam int unsigned LONG_PRESS_MS  = 4000;
  localparam int unsigned WAKE_CYC       = WAKE_US * CYC_PER_US;
  localparam int unsigned STEP_UNIT_CYC  = STEP_UNIT_US * CYC_PER_US;
  localparam int unsigned RST_UNIT_CYC   = RST_UNIT_US * CYC_PER_US;
  localparam int unsigned LONG_PRESS_CYC =
    LONG_PRESS_MS * 1000 * CYC_PER_US;

  // ------------------------------------------------------------------
  // select pin codes
  // ------------------------------------------------------------------
  localparam logic [1:0] SEL_LOW   = 2'h0;
  localparam logic [1:0] SEL_FLOAT = 2'h1;
  localparam logic [1:0] SEL_HIGH  = 2'h2;

  // ------------------------------------------------------------------
  // sequence step codes
  // ------------------------------------------------------------------
  localparam logic [1:0] STEP_ONE   = 2'h0;
  localparam logic [1:0] STEP_TWO   = 2'h1;
  localparam logic [1:0] STEP_THREE = 2'h2;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [4:0]  ADDR_CTRL  = 5'h00;
  localparam logic [4:0]  ADDR_MASK  = 5'h04;
  localparam logic [4:0]  ADDR_STS   = 5'h08;
  localparam logic [4:0]  ADDR_STATE = 5'h0c;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam int CTRL_D1_LSB  = 0;
  localparam int CTRL_D2_LSB  = 4;
  localparam int CTRL_D3_LSB  = 8;
  localparam int CTRL_RST_LSB = 12;
  localparam logic [2:0] D1_RST   = 3'h1;
  localparam logic [2:0] D2_RST   = 3'h5;
  localparam logic [2:0] D3_RST   = 3'h4;
  localparam logic [2:0] DRST_RST = 3'h4;
  localparam logic [2:0] MASK_RST = 3'h7;

  localparam int STS_THERM = 0;
  localparam int STS_OVC   = 1;
  localparam int STS_RAIL  = 2;
  localparam int STS_LONG  = 3;

  localparam int STATE_ST_LSB   = 0;
  localparam int STATE_STEP_LSB = 8;
  localparam int STATE_AUX_LSB  = 12;
  localparam int STATE_MEM_LSB  = 16;
  localparam int STATE_VLD_BIT  = 20;

  typedef enum logic [5:0] {
    ST_OFF    = 6'h01,
    ST_DELAY  = 6'h02,
    ST_RAMP   = 6'h04,
    ST_RESET_RELEASE_DELAY_FIELD = 6'h08,
    ST_RUN    = 6'h10,
    ST_HIB    = 6'h20
  } pss_state_t;
endpackage : pss_pkg

// [hdl/pss_select_capture.sv]
`timescale 1ns/1ns
module pss_select_capture (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       arm_in,
  input  wire logic       drop_in,
  input  wire logic [1:0] pin_high_in,
  input  wire logic [1:0] pin_low_in,
  output logic      [3:0] code_out,
  output logic            valid_out
);
  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } pss_cap_t;

  pss_cap_t   s_ff;
  pss_cap_t   nxt_s;
  logic [3:0] enc;

  // ------------------------------------------------------------------
  // per pin three-state encoding
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_pin
    assign enc[2*i+1:2*i] = pin_high_in[i] ? pss_pkg::SEL_HIGH :
                            pin_low_in[i]  ? pss_pkg::SEL_LOW  :
                                             pss_pkg::SEL_FLOAT;
  end

  assign code_out  = s_ff.code;
  assign valid_out = s_ff.valid;

  always_comb begin
    nxt_s = s_ff;
    if (drop_in) begin
      nxt_s.valid = 1'b0;
    end else if (arm_in && !s_ff.valid) begin
      // snapshot once; later pin changes are ignored
      nxt_s.valid = 1'b1;
      nxt_s.code  = enc;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule : pss_select_capture

// [hdl/pss_sequencer.sv]
`timescale 1ns/1ns
// How it works
// - aux select pin picks 1.8/2.5/3.3 V
// - memory select pin picks 1.2/1.35/1.8 V
// - select pins captured once at lockout release
// - capture discarded only below lower lockout
// - unmasked fault pulls interrupt pin low
// - all mask bits reset to one
// - long press interrupt is never masked
// - host reset held until sequence done, delay
// - supply, thermal or overcurrent fault asserts reset
// - hibernate entry asserts host reset
// - rails start io/aux, memory, then core
// - start on push button or hold rise
// - no hold at release means turn off
// - on a button start, button must stay low whole first delay
// - sequence ignores button once first rail enables
// - step one code 00, default 0.5 ms
// - step two code 01, default 8 ms
// - step three code 10, default 4 ms
// - reset delay default code 100, 16 ms
// - first step delay adds to wake time
// - echo pin low while button is low
module pss_sequencer #(
  parameter int unsigned WAKE_CYC       = pss_pkg::WAKE_CYC,
  parameter int unsigned STEP_UNIT_CYC  = pss_pkg::STEP_UNIT_CYC,
  parameter int unsigned RST_UNIT_CYC   = pss_pkg::RST_UNIT_CYC,
  parameter int unsigned LONG_PRESS_CYC = pss_pkg::LONG_PRESS_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        supply_above_on_in,
  input  wire logic        supply_below_off_in,
  input  wire logic        aux_sel_high_in,
  input  wire logic        aux_sel_low_in,
  input  wire logic        mem_sel_high_in,
  input  wire logic        mem_sel_low_in,
  input  wire logic        push_button_in_low_in,
  input  wire logic        power_hold_in,
  input  wire logic        low_power_request_in,
  input  wire logic [2:0]  rail_good_in,
  input  wire logic        thermal_fault_in,
  input  wire logic        overcurrent_fault_in,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             host_reset_out_low_o_out,
  output logic             host_reset_out_low_oen_out,
  output logic             fault_irq_out_low_o_out,
  output logic             fault_irq_out_low_oen_out,
  output logic             push_button_echo_low_o_out,
  output logic             push_button_echo_low_oen_out,
  output logic [2:0]       rail_enable_out,
  output logic [1:0]       sequence_step_field_out,
  output logic [1:0]       aux_rail_voltage_select_out,
  output logic [1:0]       memory_rail_voltage_select_out,
  output logic             select_valid_out
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    pss_pkg::pss_state_t st;
    logic [1:0]          step;
    logic                by_button;
    logic                hold_q;
    logic                supply_ok;
    logic                rel;
    logic [2:0]          rail_en;
    logic [2:0]          d1;
    logic [2:0]          d2;
    logic [2:0]          d3;
    logic [2:0]          drst;
    logic [2:0]          mask;
    logic [3:0]          sts;
    logic [31:0]         lp_cnt;
    logic                aw_got;
    logic [4:0]          awaddr;
    logic                w_got;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } pss_main_t;
  pss_main_t   s_ff;
  pss_main_t   nxt_s;
  logic        tmr_load;
  logic [31:0] tmr_val;
  logic        tmr_abort;
  logic        tmr_done;
  logic [3:0]  sel_code;
  logic        sel_valid;
  logic        fault_now;
  logic        irq;
  logic [31:0] ctrl_word;
  logic [31:0] state_word;
  logic [31:0] wmask;
  logic [31:0] ctrl_new;
  logic [3:0]  sts_set;
  logic [3:0]  sts_clr;
  logic        do_write;
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] step_cyc(input logic [2:0] code);
    step_cyc = 32'(STEP_UNIT_CYC) << code;
  endfunction : step_cyc
  function automatic logic [2:0] step_code(input pss_main_t s,
                                            input logic [1:0] idx);
    case (idx)
      pss_pkg::STEP_ONE: step_code = s.d1;
      pss_pkg::STEP_TWO: step_code = s.d2;
      default:           step_code = s.d3;
    endcase
  endfunction : step_code
  // ------------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------------
  pss_delay_timer u_timer (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .load_in     (tmr_load),
    .load_val_in (tmr_val),
    .abort_in    (tmr_abort),
    .done_out    (tmr_done)
  );
  pss_select_capture u_capture (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .arm_in      (s_ff.supply_ok),
    .drop_in     (supply_below_off_in),
    .pin_high_in ({mem_sel_high_in, aux_sel_high_in}),
    .pin_low_in  ({mem_sel_low_in, aux_sel_low_in}),
    .code_out    (sel_code),
    .valid_out   (sel_valid)
  );
  // ------------------------------------------------------------------
  // pins and outputs
  // ------------------------------------------------------------------
  // reset release is gated live by faults so the pin drops the same cycle
  assign fault_now = thermal_fault_in | overcurrent_fault_in |
                     ~s_ff.supply_ok | supply_below_off_in;
  assign host_reset_out_low_o_out   = 1'b0;
  assign host_reset_out_low_oen_out = s_ff.rel & ~fault_now;
  assign irq = (|(s_ff.sts[2:0] & ~s_ff.mask)) | s_ff.sts[pss_pkg::STS_LONG];
  assign fault_irq_out_low_o_out    = 1'b0;
  assign fault_irq_out_low_oen_out  = ~irq;
  assign push_button_echo_low_o_out = 1'b0;
  assign push_button_echo_low_oen_out = push_button_in_low_in;
  assign rail_enable_out                = s_ff.rail_en;
  assign sequence_step_field_out        = s_ff.step;
  assign aux_rail_voltage_select_out    = sel_code[1:0];
  assign memory_rail_voltage_select_out = sel_code[3:2];
  assign select_valid_out               = sel_valid;
  assign s_axi_awready = ~s_ff.aw_got & ~s_ff.bvalid;
  assign s_axi_wready  = ~s_ff.w_got & ~s_ff.bvalid;
  assign s_axi_bvalid  = s_ff.bvalid;
  assign s_axi_bresp   = s_ff.bresp;
  assign s_axi_arready = ~s_ff.rvalid;
  assign s_axi_rvalid  = s_ff.rvalid;
  assign s_axi_rdata   = s_ff.rdata;
  assign s_axi_rresp   = s_ff.rresp;
  // ------------------------------------------------------------------
  // register words
  // ------------------------------------------------------------------
  always_comb begin
    ctrl_word = '0;
    ctrl_word[pss_pkg::CTRL_D1_LSB +: 3]  = s_ff.d1;
    ctrl_word[pss_pkg::CTRL_D2_LSB +: 3]  = s_ff.d2;
    ctrl_word[pss_pkg::CTRL_D3_LSB +: 3]  = s_ff.d3;
    ctrl_word[pss_pkg::CTRL_RST_LSB +: 3] = s_ff.drst;
    state_word = '0;
    state_word[pss_pkg::STATE_ST_LSB +: 6]   = s_ff.st;
    state_word[pss_pkg::STATE_STEP_LSB +: 2] = s_ff.step;
    state_word[pss_pkg::STATE_AUX_LSB +: 2]  = sel_code[1:0];
    state_word[pss_pkg::STATE_MEM_LSB +: 2]  = sel_code[3:2];
    state_word[pss_pkg::STATE_VLD_BIT]       = sel_valid;
    wmask    = {{8{s_ff.wstrb[3]}}, {8{s_ff.wstrb[2]}},
                {8{s_ff.wstrb[1]}}, {8{s_ff.wstrb[0]}}};
    ctrl_new = (ctrl_word & ~wmask) | (s_ff.wdata & wmask);
  end
  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_s     = s_ff;
    tmr_load  = 1'b0;
    tmr_val   = 32'h1;
    tmr_abort = 1'b0;
    sts_set   = '0;
    sts_clr   = '0;
    do_write  = s_ff.aw_got & s_ff.w_got & ~s_ff.bvalid;
    nxt_s.hold_q    = power_hold_in;
    nxt_s.supply_ok = ~supply_below_off_in &
                      (supply_above_on_in | s_ff.supply_ok);
    sts_set[pss_pkg::STS_THERM] = thermal_fault_in;
    sts_set[pss_pkg::STS_OVC]   = overcurrent_fault_in;
    case (s_ff.st)
      pss_pkg::ST_OFF: begin
        nxt_s.rel     = 1'b0;
        nxt_s.rail_en = '0;
        nxt_s.step    = pss_pkg::STEP_ONE;
        if (!fault_now && sel_valid && (!push_button_in_low_in ||
            (power_hold_in && !s_ff.hold_q))) begin
          nxt_s.by_button = !(power_hold_in && !s_ff.hold_q);
          nxt_s.st        = pss_pkg::ST_DELAY;
          tmr_load        = 1'b1;
          tmr_val = 32'(WAKE_CYC) + step_cyc(s_ff.d1);
        end
      end
      pss_pkg::ST_DELAY: begin
        // a button start that lets go early never starts a rail
        if (s_ff.step == pss_pkg::STEP_ONE && s_ff.by_button &&
            push_button_in_low_in) begin
          nxt_s.st  = pss_pkg::ST_OFF;
          tmr_abort = 1'b1;
        end else if (tmr_done) begin
          nxt_s.rail_en[s_ff.step] = 1'b1;
          nxt_s.st = pss_pkg::ST_RAMP;
        end
      end
      pss_pkg::ST_RAMP: begin
        if (rail_good_in[s_ff.step]) begin
          tmr_load = 1'b1;
          if (s_ff.step == pss_pkg::STEP_THREE) begin
            nxt_s.st = pss_pkg::ST_RESET_RELEASE_DELAY_FIELD;
            tmr_val  = 32'(RST_UNIT_CYC) << s_ff.drst;
          end else begin
            nxt_s.step = s_ff.step + 2'h1;
            nxt_s.st   = pss_pkg::ST_DELAY;
            tmr_val    = step_cyc(step_code(s_ff, s_ff.step + 2'h1));
          end
        end
      end
      pss_pkg::ST_RESET_RELEASE_DELAY_FIELD: begin
        if (tmr_done) begin
          if (power_hold_in && (&rail_good_in)) begin
            nxt_s.rel = 1'b1;
            nxt_s.st  = pss_pkg::ST_RUN;
          end else begin
            // rel never rose, so the pin sees no high glitch
            nxt_s.st = pss_pkg::ST_OFF;
          end
        end
      end
      pss_pkg::ST_RUN: begin
        sts_set[pss_pkg::STS_RAIL] = ~(&rail_good_in);
        sts_set[pss_pkg::STS_LONG] = !push_button_in_low_in &&
          (s_ff.lp_cnt == 32'(LONG_PRESS_CYC) - 32'h1);
        if (push_button_in_low_in) begin
          nxt_s.lp_cnt = '0;
        end else if (s_ff.lp_cnt < 32'(LONG_PRESS_CYC)) begin
          nxt_s.lp_cnt = s_ff.lp_cnt + 32'h1;
        end
        if (!power_hold_in) begin
          nxt_s.rel = 1'b0;
          if (low_power_request_in) begin
            nxt_s.st      = pss_pkg::ST_HIB;
            nxt_s.rail_en = 3'h2;
          end else begin
            nxt_s.st = pss_pkg::ST_OFF;
          end
        end
      end
      pss_pkg::ST_HIB: begin
        nxt_s.rel = 1'b0;
        if (power_hold_in) begin
          nxt_s.rail_en = 3'h7;
          nxt_s.st      = pss_pkg::ST_RESET_RELEASE_DELAY_FIELD;
          tmr_load      = 1'b1;
          tmr_val       = 32'(RST_UNIT_CYC) << s_ff.drst;
        end
      end
      default: nxt_s.st = pss_pkg::ST_OFF;
    endcase
    if (s_ff.st != pss_pkg::ST_RUN) begin
      nxt_s.lp_cnt = '0;
    end
    // any system fault drops the state, reset release and rail enables at once
    if (fault_now) begin
      nxt_s.st      = pss_pkg::ST_OFF;
      nxt_s.rel     = 1'b0;
      nxt_s.rail_en = '0;
      tmr_abort     = 1'b1;
    end
    // ----------------------------------------------------------------
    // axi4-lite write
    // ----------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata;
      nxt_s.wstrb = s_axi_wstrb;
    end
    if (s_ff.bvalid && s_axi_bready) nxt_s.bvalid = 1'b0;
    if (do_write) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = pss_pkg::RESP_OKAY;
      case (s_ff.awaddr)
        pss_pkg::ADDR_CTRL: begin
          nxt_s.d1   = ctrl_new[pss_pkg::CTRL_D1_LSB +: 3];
          nxt_s.d2   = ctrl_new[pss_pkg::CTRL_D2_LSB +: 3];
          nxt_s.d3   = ctrl_new[pss_pkg::CTRL_D3_LSB +: 3];
          nxt_s.drst = ctrl_new[pss_pkg::CTRL_RST_LSB +: 3];
        end
        pss_pkg::ADDR_MASK:  if (s_ff.wstrb[0]) nxt_s.mask = s_ff.wdata[2:0];
        pss_pkg::ADDR_STS:   sts_clr = s_ff.wdata[3:0] & wmask[3:0];
        pss_pkg::ADDR_STATE: nxt_s.bresp = pss_pkg::RESP_OKAY;
        default:             nxt_s.bresp = pss_pkg::RESP_SLVERR;
      endcase
    end
    // a new event in the clearing cycle survives the clear
    nxt_s.sts = (s_ff.sts & ~sts_clr) | sts_set;
    // ----------------------------------------------------------------
    // axi4-lite read
    // ----------------------------------------------------------------
    if (s_ff.rvalid && s_axi_rready) nxt_s.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = pss_pkg::RESP_OKAY;
      case (s_axi_araddr)
        pss_pkg::ADDR_CTRL:  nxt_s.rdata = ctrl_word;
        pss_pkg::ADDR_MASK:  nxt_s.rdata = {29'h0, s_ff.mask};
        pss_pkg::ADDR_STS:   nxt_s.rdata = {28'h0, s_ff.sts};
        pss_pkg::ADDR_STATE: nxt_s.rdata = state_word;
        default: begin
          nxt_s.rdata = '0;
          nxt_s.rresp = pss_pkg::RESP_SLVERR;
        end
      endcase
    end
  end
  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_ff      <= '0;
      s_ff.st   <= pss_pkg::ST_OFF;
      s_ff.d1   <= pss_pkg::D1_RST;
      s_ff.d2   <= pss_pkg::D2_RST;
      s_ff.d3   <= pss_pkg::D3_RST;
      s_ff.drst <= pss_pkg::DRST_RST;
      s_ff.mask <= pss_pkg::MASK_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule : pss_sequencer

// [testbench/pss_host_model.sv]
`timescale 1ns/1ns
// --
// host processor and regulator model
// --
module pss_host_model (
  input  logic       mclk_in,
  input  logic       hold_req_in,
  input  logic       auto_hold_in,
  input  logic       lp_req_in,
  input  logic       reset_oen_in,
  input  logic [2:0] rail_enable_in,
  output logic            power_hold_out = 1'b0,
  output logic            low_power_out = 1'b0,
  output logic [2:0]      rail_good_out = 3'h0
);
  logic [2:0] ramp_ff = 3'h0;
  // rails settle two cycles late, so good never arrives with enable
  always @(posedge mclk_in) begin
    power_hold_out <= hold_req_in | (auto_hold_in & rail_enable_in[0]);
    low_power_out <= lp_req_in & (reset_oen_in | low_power_out);
    ramp_ff <= rail_enable_in;
    rail_good_out <= ramp_ff;
  end
endmodule : pss_host_model

// [testbench/pss_sequencer_properties.sv]
`timescale 1ns/1ns
// --
// sequencer port checks
// --
module pss_sequencer_checker (
  input logic       mclk_in,
  input logic       rst_n_in,
  input logic       push_button_in_low_in,
  input logic       power_hold_in,
  input logic       thermal_fault_in,
  input logic       overcurrent_fault_in,
  input logic       supply_below_off_in,
  input logic       host_reset_out_low_oen_out,
  input logic       fault_irq_out_low_oen_out,
  input logic       push_button_echo_low_oen_out,
  input logic [2:0] rail_enable_out,
  input logic [1:0] sequence_step_field_out,
  input logic [1:0] aux_rail_voltage_select_out,
  input logic [1:0] memory_rail_voltage_select_out,
  input logic       select_valid_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_echo_pin: assert property (push_button_echo_low_oen_out ==
    push_button_in_low_in) else $error("echo pin wrong");
  a_rst_vals: assert property (disable iff (1'b0)
    !rst_n_in |=> fault_irq_out_low_oen_out && !host_reset_out_low_oen_out)
    else $error("reset values wrong");
  a_fault_rst: assert property (thermal_fault_in || overcurrent_fault_in
    |-> !host_reset_out_low_oen_out) else $error("fault left reset free");
  a_sel_frozen: assert property (select_valid_out && !supply_below_off_in
    |=> $stable({aux_rail_voltage_select_out, memory_rail_voltage_select_out}))
    else $error("select code moved");
  a_sel_drop: assert property (supply_below_off_in
    |-> ##[1:3] !select_valid_out) else $error("select not dropped");
  a_rel_hold: assert property ($rose(host_reset_out_low_oen_out)
    |-> $past(power_hold_in)) else $error("release without hold");
  a_core_last: assert property ($rose(rail_enable_out[2])
    |-> rail_enable_out[1:0] == 2'h3 &&
    sequence_step_field_out == pss_pkg::STEP_THREE) else $error("core early");
  a_mem_second: assert property ($rose(rail_enable_out[1])
    |-> rail_enable_out[0] && sequence_step_field_out == pss_pkg::STEP_TWO)
    else $error("memory early");
  a_hold_drop: assert property ($fell(power_hold_in)
    |-> ##[0:3] !host_reset_out_low_oen_out) else $error("reset kept free");
  c_release: cover property ($rose(host_reset_out_low_oen_out));
  c_irq: cover property (!fault_irq_out_low_oen_out);
  c_sel_drop: cover property ($fell(select_valid_out));
endmodule : pss_sequencer_checker
bind pss_sequencer pss_sequencer_checker u_checker (.*);

// [testbench/test_pss_sequencer.sv]
`timescale 1ns/1ns
// --
// bench
// --
module test_pss_sequencer;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, push_button_in_low_in = 1'b1;
  logic supply_above_on_in = 1'b0, supply_below_off_in = 1'b1;
  logic aux_sel_high_in = 1'b0, aux_sel_low_in = 1'b0;
  logic mem_sel_high_in = 1'b0, mem_sel_low_in = 1'b0;
  logic thermal_fault_in = 1'b0, overcurrent_fault_in = 1'b0;
  logic hold_req = 1'b0, auto_hold = 1'b0, lp_req = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, sequence_step_field_out;
  logic [1:0] aux_rail_voltage_select_out, memory_rail_voltage_select_out;
  logic host_reset_out_low_o_out, host_reset_out_low_oen_out, select_valid_out;
  logic fault_irq_out_low_o_out, fault_irq_out_low_oen_out;
  logic push_button_echo_low_o_out, push_button_echo_low_oen_out;
  logic power_hold_in, low_power_request_in;
  logic [2:0] rail_good_in, rail_enable_out;
  logic [1:0] sel [3] = '{pss_pkg::SEL_LOW, pss_pkg::SEL_FLOAT, pss_pkg::SEL_HIGH};
  int errors = 0, total_checks = 0, cyc = 0;
  pss_sequencer #(.WAKE_CYC(2), .STEP_UNIT_CYC(4), .RST_UNIT_CYC(8),
    .LONG_PRESS_CYC(50)) dut (.*);
  pss_host_model u_host (.mclk_in(mclk_in), .hold_req_in(hold_req),
    .auto_hold_in(auto_hold), .lp_req_in(lp_req),
    .reset_oen_in(host_reset_out_low_oen_out),
    .rail_enable_in(rail_enable_out), .power_hold_out(power_hold_in),
    .low_power_out(low_power_request_in), .rail_good_out(rail_good_in));
  initial forever #10 mclk_in = ~mclk_in;
  task automatic finish_test;
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : wt
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    #1;
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wrel(output int n);
    n = 0;
    while (host_reset_out_low_oen_out !== 1'b1 && n < 2000) begin
      @(negedge mclk_in);
      n++;
    end
  endtask : wrel
  // one master; a refused channel just stays valid
  task automatic axi(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic aw, w, ar, dn;
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(negedge mclk_in);
      aw = s_axi_awready;
      w = s_axi_wready;
      ar = s_axi_arready;
      dn = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge mclk_in);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!dn);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : axi
  initial begin
    int n;
    logic [31:0] q;
    wt(4);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      aux_sel_high_in <= (i == 2);
      aux_sel_low_in <= (i == 0);
      mem_sel_high_in <= (i == 0);
      mem_sel_low_in <= (i == 2);
      supply_below_off_in <= 1'b0;
      supply_above_on_in <= 1'b1;
      wt(4);
      chk(32'(aux_rail_voltage_select_out), 32'(sel[i]));
      chk(32'(memory_rail_voltage_select_out), 32'(sel[2-i]));
      wt(1);
      aux_sel_high_in <= (i != 2);
      wt(3);
      chk(32'(aux_rail_voltage_select_out), 32'(sel[i]));
      wt(1);
      supply_above_on_in <= 1'b0;
      supply_below_off_in <= 1'b1;
      wt(4);
      chk(32'(select_valid_out), 32'h0);
      wt(1);
    end
    supply_below_off_in <= 1'b0;
    supply_above_on_in <= 1'b1;
    axi(1'b0, pss_pkg::ADDR_CTRL, 32'h0, q);
    chk(q, 32'h00004451);
    axi(1'b0, pss_pkg::ADDR_MASK, 32'h0, q);
    chk(q, 32'h00000007);
    axi(1'b0, 5'h10, 32'h0, q);
    chk(32'(rsp), 32'(pss_pkg::RESP_SLVERR));
    wt(1);
    push_button_in_low_in <= 1'b0;
    wt(5);
    push_button_in_low_in <= 1'b1;
    wt(30);
    chk(32'(rail_enable_out), 32'h0);
    wt(1);
    auto_hold <= 1'b1;
    push_button_in_low_in <= 1'b0;
    wt(15);
    push_button_in_low_in <= 1'b1;
    wt(20);
    push_button_in_low_in <= 1'b0;
    wt(3);
    push_button_in_low_in <= 1'b1;
    wrel(n);
    chk(32'(n + 38 >= 330 && n + 38 < 420), 32'h1);
    chk(32'(rail_enable_out), 32'h7);
    wt(1);
    push_button_in_low_in <= 1'b0;
    wt(60);
    chk(32'(fault_irq_out_low_oen_out), 32'h0);
    wt(1);
    push_button_in_low_in <= 1'b1;
    axi(1'b1, pss_pkg::ADDR_STS, 32'h8, q);
    chk(32'(fault_irq_out_low_oen_out), 32'h1);
    axi(1'b1, pss_pkg::ADDR_MASK, 32'h0, q);
    for (int k = 1; k < 3; k++) begin
      {overcurrent_fault_in, thermal_fault_in} <= 2'(k);
      wt(2);
      chk({host_reset_out_low_oen_out, fault_irq_out_low_oen_out}, 0);
      wt(1);
      {overcurrent_fault_in, thermal_fault_in} <= 2'h0;
      axi(1'b1, pss_pkg::ADDR_STS, 32'h3, q);
    end
    auto_hold <= 1'b0;
    wt(5);
    hold_req <= 1'b1;
    wrel(n);
    chk(32'(host_reset_out_low_oen_out), 32'h1);
    wt(1);
    lp_req <= 1'b1;
    wt(3);
    hold_req <= 1'b0;
    wt(5);
    chk(32'({host_reset_out_low_oen_out, rail_enable_out}), 32'h2);
    finish_test();
  end
endmodule : test_pss_sequencer
